// File: hdl/fault_autoreset_pkg.sv
package fault_autoreset_pkg;

  // Sources, in order: underload, overload, pump, hoist deviation, hoist comms, ext a..d
  localparam int unsigned NUM_SOURCES = 9;
  localparam int unsigned SRC_UNDERLOAD = 0;
  localparam int unsigned SRC_OVERLOAD = 1;
  localparam int unsigned SRC_PUMP = 2;
  localparam int unsigned SRC_HOIST_DEV = 3;
  localparam int unsigned SRC_HOIST_COMM = 4;
  localparam int unsigned SRC_EXT_A = 5;
  localparam int unsigned SRC_EXT_B = 6;
  localparam int unsigned SRC_EXT_C = 7;
  localparam int unsigned SRC_EXT_D = 8;

  // Sources that own a trip-reaction selector (others always coast)
  localparam logic [NUM_SOURCES-1:0] REACTION_MASK = 9'h1E3;

  // Delay setting: 0 = Off, otherwise seconds
  localparam int unsigned DELAY_W = 12;
  localparam logic [DELAY_W-1:0] DELAY_OFF = 12'h000;
  localparam logic [DELAY_W-1:0] DELAY_MAX_S = 12'hE10;

  // Reaction codes
  localparam logic REACT_COAST = 1'b0;
  localparam logic REACT_DECEL = 1'b1;

  // Interface select
  localparam logic IFSEL_SERIAL_ONLY = 1'b0;
  localparam logic IFSEL_FIELDBUS = 1'b1;

  // Timing
  localparam longint unsigned CLK_HZ = 40000000;
  localparam longint unsigned SECOND_S = 1;
  localparam int unsigned CYCLES_PER_SECOND = int'(CLK_HZ * SECOND_S);
  localparam int unsigned OPT_RESET_NS = 1000;
  localparam int unsigned OPT_RESET_CYCLES = (OPT_RESET_NS * 40 + 999) / 1000;
  localparam int unsigned OPT_RESET_W = 8;

endpackage

// File: hdl/tick_if.sv
`timescale 1ns/1ps
// Carries the one-second enable from the divider to the timers
interface tick_if;
  logic sec_tick;
  modport source (output sec_tick);
  modport sink (input sec_tick);
endinterface

// File: hdl/second_divider.sv
`timescale 1ns/1ps
// Divides mclk down to a one-cycle pulse once per second
module second_divider #(
  parameter int unsigned DIV = fault_autoreset_pkg::CYCLES_PER_SECOND
) (
  input wire logic mclk,
  input wire logic rst_n,
  tick_if.source tick
);
  localparam int unsigned CW = $clog2(DIV + 1);

  initial begin
    if (DIV < 1) begin
      $error("second_divider: DIV must be at least 1");
    end
  end

  logic [CW-1:0] cnt_ff;
  logic sec_ff;

  // Free-running divider; pulse is registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      sec_ff <= 1'b0;
    end else if (cnt_ff == CW'(DIV - 1)) begin
      cnt_ff <= '0;
      sec_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
      sec_ff <= 1'b0;
    end
  end

  assign tick.sec_tick = sec_ff;
endmodule

// File: hdl/fault_autoreset.sv
`timescale 1ns/1ps
// What this block does
// - Each source's delay count starts only once its fault input has gone inactive.
// - When a source's delay has fully run out its latched alarm is cleared if enabled.
// - Each delay accepts Off (zero) or 1 to 3600 seconds and is Off after reset.
// - Reaction value 0 makes a trip coast the motor, and coast is the reset default.
// - Reaction value 1 makes a trip bring the motor down by controlled deceleration.
// - Underload and overload each have their own delay and their own reaction selector.
// - The four external trips each have a separate delay and reaction, independently.
// - Hoist deviation and hoist comms alarms have their own delays and no reaction selector.
// - The pump alarm has its own delay, counted from fault release, same range as others.
// - Interface select 0 (default) enables the terminal port and holds the option port reset.
// - Interface select 1 enables the option port while the terminal port stays enabled.
// - The terminal port is enabled at all times whatever the interface select holds.
// - Any change of interface select gives the option module a soft reset pulse.
module fault_autoreset #(
  parameter int unsigned SEC_DIV = fault_autoreset_pkg::CYCLES_PER_SECOND,
  parameter int unsigned OPT_RESET_LEN = fault_autoreset_pkg::OPT_RESET_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  // Fault conditions, high while present
  input wire logic [fault_autoreset_pkg::NUM_SOURCES-1:0] fault_in,
  // Manual clear of latched alarms (one bit per source)
  input wire logic [fault_autoreset_pkg::NUM_SOURCES-1:0] alarm_clear,
  // Settings write port
  input wire logic cfg_we,
  input wire logic [3:0] cfg_sel,
  input wire logic [fault_autoreset_pkg::DELAY_W-1:0] cfg_delay,
  input wire logic cfg_reaction,
  input wire logic if_select,
  // Status
  output logic [fault_autoreset_pkg::NUM_SOURCES-1:0] alarm_latched,
  output logic [fault_autoreset_pkg::NUM_SOURCES-1:0] autoreset_pulse,
  output logic [fault_autoreset_pkg::NUM_SOURCES-1:0] delay_running,
  output logic [fault_autoreset_pkg::NUM_SOURCES-1:0] reaction_cfg,
  output logic hoist_deviation_reset_delay_off,
  // Motor reaction
  output logic motor_coast,
  output logic motor_decel,
  // Ports
  output logic terminal_port_en,
  output logic option_port_en,
  output logic option_port_reset
);
  // Short local names for the package's widths
  localparam int unsigned N = fault_autoreset_pkg::NUM_SOURCES;
  localparam int unsigned DW = fault_autoreset_pkg::DELAY_W;
  localparam int unsigned RW = fault_autoreset_pkg::OPT_RESET_W;

  // Refuse a stretch length that the reset counter cannot hold
  initial begin
    if (OPT_RESET_LEN < 1 || OPT_RESET_LEN > (1 << RW) - 1) begin
      $error("fault_autoreset: OPT_RESET_LEN out of range");
    end
  end

  // One shared second enable; its phase runs free and is not tied to any fault
  tick_if tick ();

  second_divider #(.DIV(SEC_DIV)) u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Per-source settings, latches and timers
  logic [DW-1:0] delay_ff [N];
  logic [N-1:0] react_ff;
  logic [N-1:0] alarm_ff;
  logic [N-1:0] pulse_ff;
  logic [N-1:0] run_ff;
  logic [DW-1:0] elapsed_ff [N];
  logic [N-1:0] nxt_alarm;

  // Settings: out-of-range delays are refused and the old value kept
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        delay_ff[i] <= fault_autoreset_pkg::DELAY_OFF;
      end
      react_ff <= '0;
    end else if (cfg_we && cfg_sel < 4'(N)) begin
      // Delays above the top of the range are refused; the old value stays
      if (cfg_delay <= fault_autoreset_pkg::DELAY_MAX_S) begin
        delay_ff[cfg_sel] <= cfg_delay;
      end
      // Pump and hoist sources have no selector, so their bits stay coast
      react_ff[cfg_sel] <= cfg_reaction & fault_autoreset_pkg::REACTION_MASK[cfg_sel];
    end
  end

  // Per-source latch and delay timer
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      logic expire;
      // Expires only once every programmed second has been counted in whole ticks; a
      // partly counted first second would otherwise shorten the wait. Off never expires
      assign expire = run_ff[g] && tick.sec_tick
                      && (delay_ff[g] != fault_autoreset_pkg::DELAY_OFF)
                      && (elapsed_ff[g] >= delay_ff[g]);

      // Fault sets win over any clear in the same cycle
      always_comb begin
        nxt_alarm[g] = alarm_ff[g];
        if (alarm_clear[g]) begin
          nxt_alarm[g] = 1'b0;
        end
        if (expire) begin
          nxt_alarm[g] = 1'b0;
        end
        if (fault_in[g]) begin
          nxt_alarm[g] = 1'b1;
        end
      end

      // Pulse marks the cycle in which an automatic clear took effect
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          alarm_ff[g] <= 1'b0;
          pulse_ff[g] <= 1'b0;
        end else begin
          alarm_ff[g] <= nxt_alarm[g];
          pulse_ff[g] <= expire && !fault_in[g];
        end
      end

      // Timer runs only with alarm latched, fault gone and delay not Off
      // The count never passes the delay, so the delay width is enough for it
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          run_ff[g] <= 1'b0;
          elapsed_ff[g] <= '0;
        end else if (fault_in[g] || !alarm_ff[g] || expire || alarm_clear[g]) begin
          run_ff[g] <= 1'b0;
          elapsed_ff[g] <= '0;
        end else if (delay_ff[g] == fault_autoreset_pkg::DELAY_OFF) begin
          run_ff[g] <= 1'b0;
          elapsed_ff[g] <= '0;
        end else begin
          run_ff[g] <= 1'b1;
          if (run_ff[g] && tick.sec_tick) begin
            elapsed_ff[g] <= elapsed_ff[g] + DW'(1);
          end
        end
      end
    end
  endgenerate

  // Trip reaction: any decel-configured latched alarm decelerates unless a coast one is latched
  logic coast_any;
  logic decel_any;
  assign coast_any = |(alarm_ff & ~react_ff);
  assign decel_any = |(alarm_ff & react_ff);

  logic coast_ff;
  logic decel_ff;
  // Coast takes priority: it is the safer reaction when both kinds are tripped
  // A decel request is dropped while any coasting alarm is latched
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      coast_ff <= 1'b0;
      decel_ff <= 1'b0;
    end else begin
      coast_ff <= coast_any;
      decel_ff <= decel_any && !coast_any;
    end
  end

  // Interface select and option-port soft reset
  logic ifsel_ff;
  logic [RW-1:0] optrst_cnt_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ifsel_ff <= fault_autoreset_pkg::IFSEL_SERIAL_ONLY;
    end else begin
      ifsel_ff <= if_select;
    end
  end

  // A change restarts the reset stretch, holding the option module for OPT_RESET_LEN cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      optrst_cnt_ff <= '0;
    end else if (if_select != ifsel_ff) begin
      optrst_cnt_ff <= RW'(OPT_RESET_LEN);
    end else if (optrst_cnt_ff != '0) begin
      optrst_cnt_ff <= optrst_cnt_ff - RW'(1);
    end
  end

  // Option enable lags the select by two cycles, in step with the reset stretch
  logic opt_en_ff;
  logic opt_rst_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opt_en_ff <= 1'b0;
      opt_rst_ff <= 1'b1;
    end else begin
      opt_en_ff <= (ifsel_ff == fault_autoreset_pkg::IFSEL_FIELDBUS);
      // Serial-only mode holds the option module in reset
      opt_rst_ff <= (ifsel_ff == fault_autoreset_pkg::IFSEL_SERIAL_ONLY)
                    || (optrst_cnt_ff != '0);
    end
  end

  // The terminal port has no off state; every other output but hoist_deviation_reset_delay_off comes from a flop
  assign terminal_port_en = 1'b1;
  assign option_port_en = opt_en_ff;
  assign option_port_reset = opt_rst_ff;
  assign alarm_latched = alarm_ff;
  assign autoreset_pulse = pulse_ff;
  assign delay_running = run_ff;
  assign reaction_cfg = react_ff;
  assign hoist_deviation_reset_delay_off =
      (delay_ff[fault_autoreset_pkg::SRC_HOIST_DEV] == fault_autoreset_pkg::DELAY_OFF);
  assign motor_coast = coast_ff;
  assign motor_decel = decel_ff;
endmodule

// File: verif/fault_src_model.sv
`timescale 1ns/1ps
// Plant sensor stand-in: holds one fault line high for HOLD cycles
module fault_src_model #(
  parameter int unsigned HOLD = 3
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [3:0] src,
  output logic [8:0] fault_in
);
  logic [7:0] left_ff;
  logic [3:0] src_ff;
  // Fault lasts several cycles so its release is a distinct event
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      left_ff <= 8'h00;
      src_ff <= 4'h0;
    end else if (go) begin
      left_ff <= 8'(HOLD);
      src_ff <= src;
    end else if (left_ff != 8'h00) begin
      left_ff <= left_ff - 8'h01;
    end
  end
  assign fault_in = (left_ff != 8'h00) ? 9'(9'h001 << src_ff) : 9'h000;
endmodule

// File: verif/fault_autoreset_monitor.sv
`timescale 1ns/1ps
// Watches the block's pins only
module fault_autoreset_monitor #(
  parameter int unsigned SEC_DIV = 10,
  parameter int unsigned OPT_RESET_LEN = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [8:0] fault_in,
  input wire logic if_select,
  input wire logic [8:0] alarm_latched,
  input wire logic [8:0] autoreset_pulse,
  input wire logic [8:0] delay_running,
  input wire logic [8:0] reaction_cfg,
  input wire logic hoist_deviation_reset_delay_off,
  input wire logic motor_coast,
  input wire logic motor_decel,
  input wire logic terminal_port_en,
  input wire logic option_port_en,
  input wire logic option_port_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_sel_change;
    $changed(if_select);
  endsequence
  // Latch, timer and automatic clear, per source
  a_fault_sets_alarm: assert property (
    |fault_in |=> (alarm_latched & $past(fault_in)) == $past(fault_in)
  ) else $error("alarm not latched");
  a_no_count_faulted: assert property (
    1 |=> (delay_running & $past(fault_in)) == 9'h000
  ) else $error("timer runs during fault");
  a_pulse_clears: assert property (
    |autoreset_pulse |-> (autoreset_pulse & (alarm_latched | ~$past(alarm_latched))) == 9'h000
  ) else $error("pulse without clear");
  a_pulse_single: assert property (
    |autoreset_pulse |=> (autoreset_pulse & $past(autoreset_pulse)) == 9'h000
  ) else $error("pulse too long");
  a_off_never: assert property (
    hoist_deviation_reset_delay_off && $past(hoist_deviation_reset_delay_off)
      |-> !autoreset_pulse[3]
  ) else $error("auto clear while off");
  // Motor reaction follows the latched alarms one cycle later
  a_coast_tracks: assert property (
    1 |=> motor_coast == |($past(alarm_latched) & ~$past(reaction_cfg))
  ) else $error("coast wrong");
  a_decel_tracks: assert property (
    1 |=> motor_decel == (!motor_coast && |$past(alarm_latched & reaction_cfg))
  ) else $error("decel wrong");
  // Port enables and the option module's soft reset
  a_terminal_on: assert property (
    1 |-> terminal_port_en
  ) else $error("terminal port off");
  a_option_lag: assert property (
    1 |-> option_port_en == $past(if_select, 2)
  ) else $error("option enable lag");
  a_sel0_held: assert property (
    !option_port_en && !$past(option_port_en) |-> option_port_reset
  ) else $error("option not held");
  a_toggle_reboot: assert property (
    s_sel_change |-> ##[1:3] option_port_reset
  ) else $error("no soft reset");
endmodule
bind fault_autoreset fault_autoreset_monitor #(
  .SEC_DIV(SEC_DIV), .OPT_RESET_LEN(OPT_RESET_LEN)
) mon (
  .mclk(mclk), .rst_n(rst_n), .fault_in(fault_in), .if_select(if_select),
  .alarm_latched(alarm_latched), .autoreset_pulse(autoreset_pulse),
  .delay_running(delay_running), .reaction_cfg(reaction_cfg),
  .hoist_deviation_reset_delay_off(hoist_deviation_reset_delay_off),
  .motor_coast(motor_coast), .motor_decel(motor_decel), .terminal_port_en(terminal_port_en),
  .option_port_en(option_port_en), .option_port_reset(option_port_reset));

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0, rst_n = 1'b0, cfg_we = 1'b0, cfg_reaction = 1'b0, if_select = 1'b0;
  logic go = 1'b0, hd_off, coast, decel, term_en, opt_en, opt_rst;
  logic [8:0] fault_in, alarm_clear = 9'h000, latched, pulse, running, react;
  logic [3:0] cfg_sel = 4'h0, src = 4'h0;
  logic [11:0] cfg_delay = 12'h000;
  int n_fail = 0, cmp_count = 0, n;
  // Short second (10 cycles) and short option reset keep the run brief
  fault_autoreset #(.SEC_DIV(10), .OPT_RESET_LEN(4)) DUT (.mclk(mclk), .rst_n(rst_n),
    .fault_in(fault_in), .alarm_clear(alarm_clear), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
    .cfg_delay(cfg_delay), .cfg_reaction(cfg_reaction), .if_select(if_select),
    .alarm_latched(latched), .autoreset_pulse(pulse), .delay_running(running),
    .reaction_cfg(react), .hoist_deviation_reset_delay_off(hd_off), .motor_coast(coast),
    .motor_decel(decel), .terminal_port_en(term_en), .option_port_en(opt_en),
    .option_port_reset(opt_rst));
  fault_src_model #(.HOLD(3)) partner (.mclk(mclk), .rst_n(rst_n), .go(go), .src(src),
    .fault_in(fault_in));
  initial forever #12.5 mclk = ~mclk;
  task automatic chk(logic [11:0] got, logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Sample 1 ns after the edge so the design's updates have landed
  task automatic cyc(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic cfg(logic [3:0] s, logic [11:0] d, logic r);
    @(posedge mclk);
    cfg_we <= 1'b1;
    cfg_sel <= s;
    cfg_delay <= d;
    cfg_reaction <= r;
    @(posedge mclk);
    cfg_we <= 1'b0;
  endtask
  task automatic trip(logic [3:0] s);
    @(posedge mclk);
    src <= s;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask
  task automatic clr;
    @(posedge mclk);
    alarm_clear <= 9'h1FF;
    @(posedge mclk);
    alarm_clear <= 9'h000;
    cyc(1);
  endtask
  // Cycles until the alarm of source s drops, capped
  task automatic wait_clear(int s);
    n = 0;
    while (latched[s] !== 1'b0 && n < 60) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_reset;
    chk(react, 12'h000);
    chk(hd_off, 12'h001);
    chk({term_en, opt_en, opt_rst}, 12'h005);
    $display("reset defaults done");
  endtask
  task automatic t_react;
    for (int i = 0; i < 10; i++) cfg(i[3:0], 12'h000, 1'b1);
    cyc(1);
    chk(react, 12'h1E3);
    trip(4'h0);
    cyc(8);
    chk({coast, decel}, 12'h001);
    trip(4'h2);
    cyc(8);
    chk({coast, decel}, 12'h002);
    clr;
    chk(latched, 12'h000);
    $display("reaction test done");
  endtask
  task automatic t_auto;
    for (int i = 0; i < 9; i++) begin
      cfg(i[3:0], 12'h002, 1'b0);
      trip(i[3:0]);
      cyc(1);
      chk({latched[i], running[i]}, 12'h002);
      wait_clear(i);
      // Two ten-cycle seconds of whole ticks after release, plus latch and release cycles
      chk(12'(n >= 24 && n <= 33), 12'h001);
      chk(pulse[i], 12'h001);
    end
    $display("auto clear test done");
  endtask
  task automatic t_restart;
    cfg(4'h5, 12'h003, 1'b0);
    trip(4'h5);
    cyc(20);
    chk({latched[5], running[5]}, 12'h003);
    trip(4'h5);
    cyc(1);
    chk(running[5], 12'h000);
    wait_clear(5);
    chk(12'(n >= 34 && n <= 43), 12'h001);
    chk(pulse[5], 12'h001);
    $display("restart test done");
  endtask
  task automatic t_off;
    cfg(4'h3, 12'h000, 1'b0);
    cfg(4'h3, 12'hFA0, 1'b0);
    cyc(1);
    chk(hd_off, 12'h001);
    trip(4'h3);
    cyc(60);
    chk({latched[3], running[3]}, 12'h002);
    clr;
    chk(latched[3], 12'h000);
    $display("off test done");
  endtask
  task automatic t_ifsel;
    @(posedge mclk);
    if_select <= 1'b1;
    cyc(4);
    chk({term_en, opt_en, opt_rst}, 12'h007);
    cyc(8);
    chk({term_en, opt_en, opt_rst}, 12'h006);
    @(posedge mclk);
    if_select <= 1'b0;
    cyc(6);
    chk({term_en, opt_en, opt_rst}, 12'h005);
    $display("interface select test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(1);
    t_reset;
    t_react;
    t_auto;
    t_restart;
    t_off;
    t_ifsel;
    print_verdict;
  end
  // Whole run needs about 520 cycles; the 4000-cycle limit, over seven times that, means a hang
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
endmodule
